// ===== core/dioirq_device.sv
// Device end: interrupt, digital I/O, secondary input functions and DAC command FIFO.
// Assumes the host holds each request until the one-cycle acknowledge; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module dioirq_device #(
    parameter int unsigned FIFO_DEPTH = dioirq_pkg::FIFO_DEPTH_DOC,
    parameter logic [7:0]  DIR_OUT    = dioirq_pkg::DIR_OUT_RESET
) (
    input  wire logic      clk_sys,
    input  wire logic      sys_rst,
    dioirq_if.device       link,
    input  wire logic [7:0] dioIn,
    output logic [7:0]     dioOut,
    output logic [7:0]     dioOe,
    input  wire logic      dmaDoneEvt,
    input  wire logic      timeoutEvt,
    input  wire logic      almostFullEvt,
    input  wire logic      overflowEvt,
    output logic           dacLoadPulse,
    output logic           streamStartPulse,
    output logic           streamClockExt,
    output logic           extStreamClockTick,
    output logic           convBeginPulse,
    output logic           convTriggerPulse,
    output logic           dacCmdValid,
    output logic [31:0]    dacCmdData,
    input  wire logic      dacCmdReady,
    output logic [2:0]     channelsPerPoint
);
    localparam int unsigned PTR_W = $clog2(FIFO_DEPTH);

    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
        $error("FIFO_DEPTH must be a power of two, at least 2");
    end

    // Edge of the configured polarity between two filtered samples
    function automatic logic edgeHit(input logic prev, input logic cur, input logic rising);
        edgeHit = rising ? (cur & ~prev) : (prev & ~cur);
    endfunction

    logic [7:0]       syncA;
    logic [7:0]       syncB;
    logic [7:0]       syncC;
    logic [7:0]       pinLevel;
    logic [7:0]       pinPrev;
    logic [7:0]       irqStatus;
    logic [7:0]       irqEnable;
    logic [7:0]       outLatch;
    logic [31:0]      dioCtrl;
    logic [7:0]       events;
    logic             accept;
    logic             wrIrq;
    logic             pushReq;
    logic             popMem;
    logic [31:0]      mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0]   memCount;
    logic [PTR_W:0]   fifoLevel;
    logic [31:0]      next_rdata;

    assign accept = link.regReq & ~link.regAck;
    assign wrIrq  = accept & link.regWrite & (link.regAddr == dioirq_pkg::OFF_IRQ);

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            syncA    <= 8'h00;
            syncB    <= 8'h00;
            syncC    <= 8'h00;
            pinLevel <= 8'h00;
            pinPrev  <= 8'h00;
        end else begin
            syncA    <= dioIn;
            syncB    <= syncA;
            syncC    <= syncB;
            pinLevel <= (syncB & ~(syncB ^ syncC)) | (pinLevel & (syncB ^ syncC));
            pinPrev  <= pinLevel;
        end
    end

    // Interrupt events; the four pin functions are each gated by their enable and edge choice, the others pass straight through
    always_comb begin
        events = 8'h00;
        events[dioirq_pkg::EV_DMA_DONE]    = dmaDoneEvt;
        events[dioirq_pkg::EV_TIMEOUT]     = timeoutEvt;
        events[dioirq_pkg::EV_ALMOST_FULL] = almostFullEvt;
        events[dioirq_pkg::EV_OVERFLOW]    = overflowEvt;
        events[dioirq_pkg::EV_EXT_IRQ]     = dioCtrl[dioirq_pkg::SEL_EXT_IRQ]
            & edgeHit(pinPrev[dioirq_pkg::PIN_EXT], pinLevel[dioirq_pkg::PIN_EXT],
                      dioCtrl[dioirq_pkg::SEL_EXT_IRQ + 1]);
        events[dioirq_pkg::EV_LOAD]        = dioCtrl[dioirq_pkg::SEL_LOAD]
            & edgeHit(pinPrev[dioirq_pkg::PIN_LOAD], pinLevel[dioirq_pkg::PIN_LOAD],
                      dioCtrl[dioirq_pkg::SEL_LOAD + 1]);
        events[dioirq_pkg::EV_CONV_BEGIN]  = dioCtrl[dioirq_pkg::SEL_CONV_BEGIN]
            & edgeHit(pinPrev[dioirq_pkg::PIN_CONV_BEGIN], pinLevel[dioirq_pkg::PIN_CONV_BEGIN],
                      dioCtrl[dioirq_pkg::SEL_CONV_BEGIN + 1]);
        events[dioirq_pkg::EV_CONV_TRIG]   = dioCtrl[dioirq_pkg::SEL_CONV_TRIG]
            & edgeHit(pinPrev[dioirq_pkg::PIN_CONV_TRIG], pinLevel[dioirq_pkg::PIN_CONV_TRIG],
                      dioCtrl[dioirq_pkg::SEL_CONV_TRIG + 1]);
    end

    // Strobes to the DAC and ADC engines, one cycle each, plus the streamClockExt select level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dacLoadPulse       <= 1'b0;
            streamStartPulse   <= 1'b0;
            extStreamClockTick <= 1'b0;
            convBeginPulse     <= 1'b0;
            convTriggerPulse   <= 1'b0;
            streamClockExt     <= 1'b0;
        end else begin
            dacLoadPulse       <= events[dioirq_pkg::EV_LOAD];
            streamStartPulse   <= dioCtrl[dioirq_pkg::SEL_STREAM]
                & edgeHit(pinPrev[dioirq_pkg::PIN_LOAD], pinLevel[dioirq_pkg::PIN_LOAD],
                          dioCtrl[dioirq_pkg::SEL_STREAM + 1]);
            streamClockExt     <= dioCtrl[dioirq_pkg::SEL_EXT_CLOCK];
            extStreamClockTick <= dioCtrl[dioirq_pkg::SEL_EXT_CLOCK]
                & edgeHit(pinPrev[dioirq_pkg::PIN_EXT], pinLevel[dioirq_pkg::PIN_EXT],
                          dioCtrl[dioirq_pkg::SEL_EXT_CLOCK + 1]);
            convBeginPulse     <= events[dioirq_pkg::EV_CONV_BEGIN];
            convTriggerPulse   <= events[dioirq_pkg::EV_CONV_TRIG];
        end
    end

    // Status latches only for enabled sources; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus <= 8'h00;
            irqEnable <= 8'h00;
        end else begin
            if (wrIrq) begin
                irqStatus <= (irqStatus & ~link.regWdata[dioirq_pkg::STATUS_LSB +: 8])
                             | (events & irqEnable);
                irqEnable <= link.regWdata[7:0];
            end else begin
                irqStatus <= irqStatus | (events & irqEnable);
            end
        end
    end

    // Interrupt request follows pending enabled status one cycle later
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            link.irqReq <= 1'b0;
        end else begin
            link.irqReq <= |(irqStatus & irqEnable);
        end
    end

    // Control, output data and channels per point
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dioCtrl          <= 32'h00000000;
            outLatch         <= 8'h00;
            channelsPerPoint <= dioirq_pkg::CPP_RESET;
        end else if (accept && link.regWrite) begin
            case (link.regAddr)
                dioirq_pkg::OFF_DIGITAL_IO_DATA: outLatch <= link.regWdata[7:0];
                dioirq_pkg::OFF_DIO_CTRL: dioCtrl <= link.regWdata & dioirq_pkg::CTRL_MASK;
                dioirq_pkg::OFF_CPP: begin
                    // Out-of-range values are ignored so playback never sees zero channels
                    if (link.regWdata >= 32'h00000001 && link.regWdata <= 32'h00000004) begin
                        channelsPerPoint <= link.regWdata[2:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Output lines drive only where the group is an output
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dioOut <= 8'h00;
            dioOe  <= 8'h00;
        end else begin
            dioOut <= outLatch & DIR_OUT;
            dioOe  <= DIR_OUT;
        end
    end

    // Command FIFO: full writes are dropped; the head moves to a registered output stage
    assign pushReq = accept & link.regWrite & (link.regAddr == dioirq_pkg::OFF_FIFO)
                     & (fifoLevel != (PTR_W + 1)'(FIFO_DEPTH));
    assign popMem  = (memCount != '0) & (~dacCmdValid | dacCmdReady);

    always_ff @(posedge clk_sys) begin
        if (pushReq) begin
            mem[wrPtr] <= link.regWdata;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr       <= '0;
            rdPtr       <= '0;
            memCount    <= '0;
            fifoLevel   <= '0;
            dacCmdValid <= 1'b0;
            dacCmdData  <= 32'h00000000;
        end else begin
            if (pushReq) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (popMem) begin
                rdPtr      <= rdPtr + 1'b1;
                dacCmdData <= mem[rdPtr];
            end
            if (popMem) begin
                dacCmdValid <= 1'b1;
            end else if (dacCmdReady) begin
                dacCmdValid <= 1'b0;
            end
            memCount  <= memCount + (PTR_W + 1)'(pushReq) - (PTR_W + 1)'(popMem);
            fifoLevel <= fifoLevel + (PTR_W + 1)'(pushReq) - (PTR_W + 1)'(dacCmdValid & dacCmdReady);
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h00000000;
        case (link.regAddr)
            dioirq_pkg::OFF_IRQ:       next_rdata = {8'h00, irqStatus, 8'h00, irqEnable};
            dioirq_pkg::OFF_DIGITAL_IO_DATA:  next_rdata = {24'h000000,
                                        (outLatch & DIR_OUT) | (pinLevel & ~DIR_OUT)};
            dioirq_pkg::OFF_DIO_CTRL:  next_rdata = dioCtrl;
            dioirq_pkg::OFF_FIFO:      next_rdata = 32'(fifoLevel);
            dioirq_pkg::OFF_CPP:       next_rdata = {29'h00000000, channelsPerPoint};
            dioirq_pkg::OFF_FIFO_SIZE: next_rdata = 32'(FIFO_DEPTH);
            default:                   next_rdata = 32'h00000000;
        endcase
    end

    // One answer per request, the cycle after it is taken; every access is a full word
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            link.regAck   <= 1'b0;
            link.regRdata <= 32'h00000000;
        end else begin
            link.regAck <= accept;
            if (accept && !link.regWrite) begin
                link.regRdata <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/dioirq_host.sv
// Host end: an APB slave whose own registers order single-word accesses to the device.
// Assumes APB on the same clock; the device answers each request with a one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
module dioirq_host (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    dioirq_if.host           link
);
    typedef enum logic [1:0] {IDLE, WAIT} dioirq_state_t;

    dioirq_state_t state;
    logic [7:0]    cmdAddr;
    logic [31:0]   cmdWdata;
    logic [31:0]   readBack;
    logic          done;
    logic          apbDone;
    logic          apbWr;
    logic          startCmd;
    logic          mapped;

    // APB access completes at the edge where pready is seen high
    assign apbDone  = psel & penable & pready;
    assign apbWr    = apbDone & pwrite;
    assign startCmd = apbWr & (paddr == dioirq_pkg::HOFF_CTRL) & pwdata[dioirq_pkg::CTRL_START]
                      & (state == IDLE);
    assign mapped   = (paddr == dioirq_pkg::HOFF_ADDR) | (paddr == dioirq_pkg::HOFF_WDATA)
                      | (paddr == dioirq_pkg::HOFF_CTRL) | (paddr == dioirq_pkg::HOFF_STATUS)
                      | (paddr == dioirq_pkg::HOFF_RDATA);

    // One wait state, then answer; read data and error are registered at the same edge as pready
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready) begin
                case (paddr)
                    dioirq_pkg::HOFF_ADDR:   prdata <= {24'h000000, cmdAddr};
                    dioirq_pkg::HOFF_WDATA:  prdata <= cmdWdata;
                    dioirq_pkg::HOFF_STATUS: prdata <= {29'h00000000, link.irqReq, done,
                                                        state == WAIT};
                    dioirq_pkg::HOFF_RDATA:  prdata <= readBack;
                    default:                 prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Address and write data of the next device access
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmdAddr  <= 8'h00;
            cmdWdata <= 32'h00000000;
        end else begin
            if (apbWr && paddr == dioirq_pkg::HOFF_ADDR) begin
                cmdAddr <= pwdata[7:0] & 8'hFC;    // Word aligned, full 32-bit accesses only
            end
            if (apbWr && paddr == dioirq_pkg::HOFF_WDATA) begin
                cmdWdata <= pwdata;
            end
        end
    end

    // Request held until the device acknowledges; a start while busy is ignored
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= IDLE;
            link.regReq   <= 1'b0;
            link.regWrite <= 1'b0;
            link.regAddr  <= 8'h00;
            link.regWdata <= 32'h00000000;
            readBack      <= 32'h00000000;
            done          <= 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    if (startCmd) begin
                        state         <= WAIT;
                        link.regReq   <= 1'b1;
                        link.regWrite <= pwdata[dioirq_pkg::CTRL_WRITE];
                        link.regAddr  <= cmdAddr;
                        link.regWdata <= cmdWdata;
                        done          <= 1'b0;
                    end
                end
                WAIT: begin
                    if (link.regAck) begin
                        state       <= IDLE;
                        link.regReq <= 1'b0;
                        done        <= 1'b1;
                        if (!link.regWrite) begin
                            readBack <= link.regRdata;
                        end
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== core/dioirq_if.sv
// Register link between the host controller and the device register block.
// Assumes one shared clock; every signal is driven from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
interface dioirq_if;
    logic        regReq;   // Held by host until regAck
    logic        regWrite;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic        regAck;   // One-cycle answer
    logic        irqReq;   // Level interrupt request

    modport device (input regReq, input regWrite, input regAddr, input regWdata,
                    output regRdata, output regAck, output irqReq);
    modport host (output regReq, output regWrite, output regAddr, output regWdata,
                  input regRdata, input regAck, input irqReq);
endinterface
`default_nettype wire

// ===== core/dioirq_pkg.sv
// Shared constants of the digital I/O, interrupt and DAC waveform register block.
// Assumes both ends are built from the same copy of this package.
package dioirq_pkg;
    // Device register offsets (byte addresses, one 32-bit word each)
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  OFF_IRQ         = 8'h40;
    localparam logic [7:0]  OFF_DIGITAL_IO_DATA    = 8'h44;
    localparam logic [7:0]  OFF_DIO_CTRL    = 8'h48;
    localparam logic [7:0]  OFF_FIFO        = 8'h50;
    localparam logic [7:0]  OFF_CPP         = 8'h54;
    localparam logic [7:0]  OFF_FIFO_SIZE   = 8'h58;
    // Interrupt register: status byte at 23..16, enable byte at 7..0
    localparam int unsigned STATUS_LSB      = 16;
    localparam int unsigned EV_CONV_TRIG    = 0;
    localparam int unsigned EV_CONV_BEGIN   = 1;
    localparam int unsigned EV_DMA_DONE     = 2;
    localparam int unsigned EV_TIMEOUT      = 3;
    localparam int unsigned EV_ALMOST_FULL  = 4;
    localparam int unsigned EV_OVERFLOW     = 5;
    localparam int unsigned EV_LOAD         = 6;
    localparam int unsigned EV_EXT_IRQ      = 7;
    // Secondary function enables; the polarity bit sits one above each
    localparam int unsigned SEL_CONV_TRIG   = 16;
    localparam int unsigned SEL_CONV_BEGIN  = 18;
    localparam int unsigned SEL_LOAD        = 20;
    localparam int unsigned SEL_EXT_IRQ     = 22;
    localparam int unsigned SEL_STREAM      = 24;
    localparam int unsigned SEL_EXT_CLOCK   = 26;
    localparam logic [31:0] CTRL_MASK       = 32'h0FFF0000;
    // Digital lines carrying secondary functions
    localparam int unsigned PIN_LOAD        = 4;
    localparam int unsigned PIN_EXT         = 5;
    localparam int unsigned PIN_CONV_BEGIN  = 6;
    localparam int unsigned PIN_CONV_TRIG   = 7;
    // Reset values and limits
    localparam logic [7:0]  DIR_OUT_RESET   = 8'h0F;
    localparam logic [2:0]  CPP_RESET       = 3'h1;
    localparam logic [2:0]  CPP_MAX         = 3'h4;
    localparam int unsigned FIFO_DEPTH_DOC  = 8192;
    // Controller's own APB registers
    localparam logic [7:0]  HOFF_ADDR       = 8'h00;
    localparam logic [7:0]  HOFF_WDATA      = 8'h04;
    localparam logic [7:0]  HOFF_CTRL       = 8'h08;
    localparam logic [7:0]  HOFF_STATUS     = 8'h0C;
    localparam logic [7:0]  HOFF_RDATA      = 8'h10;
    localparam int unsigned CTRL_START      = 0;
    localparam int unsigned CTRL_WRITE      = 1;
    localparam int unsigned ST_BUSY         = 0;
    localparam int unsigned ST_DONE         = 1;
    localparam int unsigned ST_IRQ          = 2;
endpackage

// ===== tb/dioirq_assertions.sv
// Checker of the register link between the host and device ends.
// Assumes one clock; tb places it beside the interface instance.
`timescale 1ns/1ps
`default_nettype none
module dioirq_assertions #(
    parameter int unsigned FIFO_DEPTH = dioirq_pkg::FIFO_DEPTH_DOC
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        regReq,
    input  wire logic        regWrite,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic [31:0] regRdata,
    input  wire logic        regAck,
    input  wire logic        irqReq
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [7:0] enShadow;
    logic       rdAck;
    // Read answer; address and direction are still held in the ack cycle
    assign rdAck = regAck && !regWrite;
    // Enable byte as last written; it lags the device by one edge
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            enShadow <= 8'h00;
        else if (regAck && regWrite && regAddr == dioirq_pkg::OFF_IRQ)
            enShadow <= regWdata[7:0];
    end
    a_ack_single: assert property (regAck |=> !regAck) else $error("ack held too long");
    a_ack_follows: assert property (regReq && !regAck |=> regAck) else $error("no ack");
    a_ack_cause: assert property (regAck |-> $past(regReq)) else $error("ack without request");
    a_size_value: assert property (rdAck && regAddr == dioirq_pkg::OFF_FIFO_SIZE |->
        regRdata == FIFO_DEPTH) else $error("size register wrong");
    a_data_upper: assert property (rdAck && regAddr == dioirq_pkg::OFF_DIGITAL_IO_DATA |->
        regRdata[31:8] == 24'h0) else $error("data upper bits set");
    a_irq_layout: assert property (rdAck && regAddr == dioirq_pkg::OFF_IRQ |->
        {regRdata[31:24], regRdata[15:8]} == 16'h0) else $error("interrupt unused bits set");
    a_enable_hold: assert property (rdAck && regAddr == dioirq_pkg::OFF_IRQ |->
        regRdata[7:0] == enShadow) else $error("enable byte changed");
    a_ctrl_unused: assert property (rdAck && regAddr == dioirq_pkg::OFF_DIO_CTRL |->
        (regRdata & ~dioirq_pkg::CTRL_MASK) == 32'h0) else $error("control unused bits set");
    a_cpp_range: assert property (rdAck && regAddr == dioirq_pkg::OFF_CPP |->
        regRdata inside {[1:4]}) else $error("channels per point out of range");
    a_irq_masked: assert property (enShadow == 8'h00 && $past(enShadow) == 8'h00 |->
        !irqReq) else $error("request with nothing enabled");
    c_irq_rise: cover property ($rose(irqReq));
    c_irq_write: cover property (regAck && regWrite && regAddr == dioirq_pkg::OFF_IRQ);
    c_size_read: cover property (rdAck && regAddr == dioirq_pkg::OFF_FIFO_SIZE);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Testbench: APB master on the host end, pins and events on the device end.
// Assumes FIFO depth cut to 8 so that a fill stays short.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int unsigned DEPTH = 8;
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err, clkExt, dacCmdValid, dacCmdReady;
    logic [7:0]  paddr, dioIn, dioOut, dioOe;
    logic [31:0] pwdata, prdata, dacCmdData, rd, v, seed, q[$];
    logic [4:0]  pl;
    logic [3:0]  evt;
    logic [2:0]  cpp;
    int          fail_count, n_tests, pulses, i, k, pin[6], ev[6];
    dioirq_if dioirq_if_i();
    dioirq_host dioirq_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(dioirq_if_i.host));
    dioirq_device #(.FIFO_DEPTH(DEPTH)) dioirq_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .link(dioirq_if_i.device), .dioIn(dioIn), .dioOut(dioOut), .dioOe(dioOe), .dmaDoneEvt(evt[0]),
        .timeoutEvt(evt[1]), .almostFullEvt(evt[2]), .overflowEvt(evt[3]), .dacLoadPulse(pl[0]),
        .streamStartPulse(pl[1]), .streamClockExt(clkExt), .extStreamClockTick(pl[2]),
        .convBeginPulse(pl[3]), .convTriggerPulse(pl[4]), .dacCmdValid(dacCmdValid),
        .dacCmdData(dacCmdData), .dacCmdReady(dacCmdReady), .channelsPerPoint(cpp));
    dioirq_assertions #(.FIFO_DEPTH(DEPTH)) dioirq_assertions_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .regReq(dioirq_if_i.regReq), .regWrite(dioirq_if_i.regWrite), .regAddr(dioirq_if_i.regAddr),
        .regWdata(dioirq_if_i.regWdata), .regRdata(dioirq_if_i.regRdata), .regAck(dioirq_if_i.regAck),
        .irqReq(dioirq_if_i.irqReq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; starts on a fresh edge so psel is never set twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Device access ordered through the host registers, polled until done
    task automatic dev(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, dioirq_pkg::HOFF_ADDR, {24'h0, a});
        apb(1'b1, dioirq_pkg::HOFF_WDATA, d);
        apb(1'b1, dioirq_pkg::HOFF_CTRL, {30'h0, w, 1'b1});
        do apb(1'b0, dioirq_pkg::HOFF_STATUS, 32'h0); while (rd[dioirq_pkg::ST_DONE] !== 1'b1);
        if (!w)
            apb(1'b0, dioirq_pkg::HOFF_RDATA, 32'h0);
    endtask
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // About 50k cycles, several times the expected run
    initial begin
        #2000000;
        fail_count++;
        summarize();
    end
    // Pulse count and in-order check of drained FIFO words
    always @(posedge clk_sys) begin
        if (|pl)
            pulses++;
        if (dacCmdValid === 1'b1 && dacCmdReady === 1'b1)
            chk(dacCmdData, q.size() > 0 ? q.pop_front() : 32'hDEAD0000);
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, dioIn, evt, dacCmdReady} = '0;
        {fail_count, n_tests, pulses} = '0;
        pin = '{7, 6, 4, 5, 4, 5};
        ev = '{0, 1, 6, 7, 8, 8};
        seed = 32'h79F2006A;
        sys_rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        dev(1'b1, dioirq_pkg::OFF_FIFO_SIZE, 32'h5);
        dev(1'b0, dioirq_pkg::OFF_FIFO_SIZE, 32'h0);
        chk(rd, DEPTH);
        chk(32'(dioOe), 32'(dioirq_pkg::DIR_OUT_RESET));
        dev(1'b0, 8'h5C, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        // Values outside 1..4 keep the last accepted count
        for (i = 0; i < 6; i++) begin
            dev(1'b1, dioirq_pkg::OFF_CPP, i);
            dev(1'b0, dioirq_pkg::OFF_CPP, 32'h0);
            k = (i == 0) ? 1 : (i > 4 ? 4 : i);
            chk(rd, k);
            chk(32'(cpp), k);
        end
        for (i = 0; i < 4; i++) begin
            k = $random(seed);
            dev(1'b1, dioirq_pkg::OFF_DIO_CTRL, k);
            dev(1'b0, dioirq_pkg::OFF_DIO_CTRL, 32'h0);
            chk(rd, k & dioirq_pkg::CTRL_MASK);
            chk(32'(clkExt), k[dioirq_pkg::SEL_EXT_CLOCK]);
            dioIn <= k[15:8];
            dev(1'b1, dioirq_pkg::OFF_DIGITAL_IO_DATA, k);
            chk(32'(dioOut), k[7:0] & dioirq_pkg::DIR_OUT_RESET);
            dev(1'b0, dioirq_pkg::OFF_DIGITAL_IO_DATA, 32'h0);
            chk(rd, (k[7:0] & dioirq_pkg::DIR_OUT_RESET) | (k[15:8] & ~dioirq_pkg::DIR_OUT_RESET));
        end
        // Masked events must not latch; enabled ones latch, survive a write with a zero status byte, clear on write-back
        dioIn <= 8'hFF;
        dev(1'b1, dioirq_pkg::OFF_IRQ, 32'h0);
        evt <= 4'hF;
        @(posedge clk_sys);
        evt <= 4'h0;
        dev(1'b0, dioirq_pkg::OFF_IRQ, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 4; i++) begin
            dev(1'b1, dioirq_pkg::OFF_IRQ, 32'hFF);
            evt <= 4'h1 << i;
            @(posedge clk_sys);
            evt <= 4'h0;
            dev(1'b1, dioirq_pkg::OFF_IRQ, 32'hFF);
            dev(1'b0, dioirq_pkg::OFF_IRQ, 32'h0);
            v = rd;
            chk(v, (32'h40000 << i) | 32'hFF);
            apb(1'b0, dioirq_pkg::HOFF_STATUS, 32'h0);
            chk(32'(rd[dioirq_pkg::ST_IRQ]), 32'h1);
            dev(1'b1, dioirq_pkg::OFF_IRQ, v);
            dev(1'b0, dioirq_pkg::OFF_IRQ, 32'h0);
            chk(rd, 32'hFF);
            apb(1'b0, dioirq_pkg::HOFF_STATUS, 32'h0);
            chk(32'(rd[dioirq_pkg::ST_IRQ]), 32'h0);
        end
        // Each pin function, polarity alternating: the other edge does nothing, the chosen one fires
        for (i = 0; i < 6; i++) begin
            v = i[0] ? 32'h0 : 32'hFF;
            dioIn <= v[7:0];
            dev(1'b1, dioirq_pkg::OFF_DIO_CTRL, (i[0] ? 32'h1 : 32'h3) << (16 + 2 * i));
            k = pulses;
            dioIn <= ~v[7:0];
            dev(1'b0, dioirq_pkg::OFF_IRQ, 32'h0);
            chk(rd, 32'hFF);
            chk(pulses - k, 32'h0);
            dioIn <= v[7:0];
            repeat (12) @(posedge clk_sys);
            chk(pulses - k, (i == 3) ? 0 : 1);
            dev(1'b0, dioirq_pkg::OFF_IRQ, 32'h0);
            chk(rd, {8'h0, 8'(1 << ev[i]), 8'h0, 8'hFF});
            dev(1'b1, dioirq_pkg::OFF_IRQ, rd);
            dev(1'b0, dioirq_pkg::OFF_DIGITAL_IO_DATA, 32'h0);
            chk(32'(rd[pin[i]]), 32'(v[0]));
        end
        // Fill past capacity with the drain stalled, then drain and compare order
        for (i = 0; i <= DEPTH; i++) begin
            k = $random(seed) & 32'h0007FFFF;
            dev(1'b1, dioirq_pkg::OFF_FIFO, k);
            if (i < DEPTH)
                q.push_back(k);
        end
        repeat (2) begin
            dev(1'b0, dioirq_pkg::OFF_FIFO, 32'h0);
            chk(rd, DEPTH);
        end
        dacCmdReady <= 1'b1;
        repeat (4 * DEPTH) @(posedge clk_sys);
        dev(1'b0, dioirq_pkg::OFF_FIFO, 32'h0);
        chk(rd, 32'h0);
        chk(q.size(), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
